// ==== hdl/host_port_cfg.svh ====
// host_port_cfg.svh: constants for the host bus and dma request port
// assumes inclusion by bare name; definitions only
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// register index map (index on the 8-bit address bus)
`define REG_IRQ_STATUS_FIRST  8'h00
`define REG_IRQ_STATUS_SECOND 8'h01
`define REG_IRQ_STATUS_THIRD  8'h02
`define REG_IRQ_MASK_FIRST    8'h04
`define REG_IRQ_MASK_SECOND   8'h05
`define REG_IRQ_MASK_THIRD    8'h06
`define REG_TX_BYTE_COUNT_LOW  8'h08
`define REG_TX_BYTE_COUNT_HIGH 8'h09
`define REG_FIFO_DATA         8'h10

// reset values
`define IRQ_MASK_RESET        8'hFF
`define TX_COUNT_RESET        16'h0000
`define PIN_IDLE_RESET        23'h1FF800

// transfer block size in bytes
`define DMA_BLOCK_BYTES       16'h0020

// ready delay after strobe seen, cycles (at 250 MHz)
`define READY_DELAY_CYC       2'h1

`endif

// ==== hdl/host_port_pkg.sv ====
// host_port_pkg: types shared by the host port files
// assumes the cfg header supplies the numbers
package host_port_pkg;
	// bus access state
	typedef enum logic [1:0] {
		acc_idle_type_s = 2'b00,
		acc_wait_s      = 2'b01,
		acc_ready_s     = 2'b10
	} acc_state_type;
	// bus style seen on the style pin
	typedef enum logic [1:0] {
		style_separate = 2'b00,
		style_strobe   = 2'b01,
		style_muxed    = 2'b10
	} bus_style_type;
endpackage

// ==== hdl/word_fifo.sv ====
// word_fifo: synchronous fifo, valid/ready on both sides
// assumes one clock, clock enable freezing all state
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             clk_en,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	wire              push;
	wire              pop;

	// handshake terms
	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rd_ptr_r];
	assign level     = count_r;

	// pointers and count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else if (clk_en) begin
			if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (clk_en && push) mem_r[wr_ptr_r] <= in_data;
	end
endmodule // word_fifo
`default_nettype wire

// ==== hdl/host_bus_and_dma_request_port.sv ====
// host_bus_and_dma_request_port: slave host bus port with dma requests
// assumes bus pins arrive asynchronously and are synchronised here;
// assumes the serial side feeds rx bytes and drains tx bytes by valid/ready
`timescale 1ns/1ns
`default_nettype none
`include "host_port_cfg.svh"
module host_bus_and_dma_request_port
	import host_port_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int RX_BLOCK   = 32
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// bus configuration pins
	input  wire logic        bus_width_sel,
	input  wire logic        bus_style_select,
	// address, select and strobes (active low)
	input  wire logic [7:0]  addr_in,
	input  wire logic        chip_select_n,
	input  wire logic        read_n,
	input  wire logic        write_n,
	input  wire logic        read_write,
	input  wire logic        data_strobe_n,
	input  wire logic        low_byte_enable,
	input  wire logic        high_byte_enable,
	input  wire logic        lower_byte_strobe,
	input  wire logic        upper_byte_strobe,
	// data bus, three signals per pin
	input  wire logic [15:0] data_in,
	output logic [15:0]      data_out,
	output logic [15:0]      data_oe_n,
	// ready / acknowledge, three-state
	output logic             transfer_ack_out,
	output logic             transfer_ack_oe_n,
	// interrupt request and its enable
	output logic             irq_out,
	output logic             irq_oe_n,
	// dma channel a
	output logic             tx_dma_request_a,
	output logic             rx_dma_request_a,
	output logic             dma_req_oe_n,
	input  wire logic        dma_grant_ack_a,
	// interrupt events from the channel logic (one-cycle pulses)
	input  wire logic [23:0] irq_event,
	// serial side: tx bytes out, rx bytes in
	output logic             tx_byte_valid,
	input  wire logic        tx_byte_ready,
	output logic [7:0]       tx_byte_data,
	input  wire logic        rx_byte_valid,
	output logic             rx_byte_ready,
	input  wire logic [7:0]  rx_byte_data,
	// status
	output logic [15:0]      tx_bytes_left
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// two-flop synchronisers for every pin input
	logic [22:0] pin_s1_r;
	logic [22:0] pin_s2_r;
	logic [7:0]  ale_addr_r;
	logic [15:0] din_s1_r;
	logic [15:0] din_s2_r;
	wire  [22:0] pin_raw = {bus_width_sel, bus_style_select, chip_select_n, read_n, write_n,
		read_write, data_strobe_n, low_byte_enable, high_byte_enable, lower_byte_strobe,
		upper_byte_strobe, dma_grant_ack_a, addr_in, 3'h0};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1_r <= `PIN_IDLE_RESET;
			pin_s2_r <= `PIN_IDLE_RESET;
			din_s1_r <= '0;
			din_s2_r <= '0;
		end else if (clk_en) begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			din_s1_r <= data_in;
			din_s2_r <= din_s1_r;
		end
	end

	wire       width16  = pin_s2_r[22];
	wire       style_s  = pin_s2_r[21];
	wire       cs_n_s   = pin_s2_r[20];
	wire       rd_n_s   = pin_s2_r[19];
	wire       wr_n_s   = pin_s2_r[18];
	wire       rw_s     = pin_s2_r[17];
	wire       ds_n_s   = pin_s2_r[16];
	wire       ble_s    = pin_s2_r[15];
	wire       bhe_s    = pin_s2_r[14];
	wire       lds_s    = pin_s2_r[13];
	wire       uds_s    = pin_s2_r[12];
	wire       dack_n_s = pin_s2_r[11];
	wire [7:0] addr_s   = pin_s2_r[10:3];

	// bus style: a falling style pin edge latches muxed mode and the address
	bus_style_type style_r;
	logic          style_prev_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			style_r      <= style_separate;
			style_prev_r <= 1'b0;
			ale_addr_r   <= '0;
		end else if (clk_en) begin
			style_prev_r <= style_s;
			if (style_prev_r && !style_s) begin
				style_r    <= style_muxed;
				ale_addr_r <= din_s2_r[7:0];
			end else if (style_r != style_muxed) begin
				style_r <= style_s ? style_strobe : style_separate;
			end
		end
	end

	// strobe decode per style; low-true pins turned into active-high terms
	wire is_strobe   = (style_r == style_strobe);
	wire rd_strobe   = is_strobe ? ((!ds_n_s || (width16 && (!lds_s || !uds_s))) && rw_s)
		: !rd_n_s;
	wire wr_strobe   = is_strobe ? ((!ds_n_s || (width16 && (!lds_s || !uds_s))) && !rw_s)
		: !wr_n_s;
	// lane enables: 8-bit uses low lane only; 16-bit honours byte selects
	wire lane_lo     = !width16 || (is_strobe ? !lds_s : !ble_s);
	wire lane_hi     = width16 && (is_strobe ? !uds_s : !bhe_s);
	wire dma_cycle   = !dack_n_s;
	wire reg_sel     = !cs_n_s && !dma_cycle;
	wire any_strobe  = rd_strobe || wr_strobe;
	wire access_on   = any_strobe && (reg_sel || dma_cycle);
	wire [7:0] reg_a = (style_r == style_muxed) ? ale_addr_r : addr_s;

	// access state machine: one cycle per strobe, ready until release
	acc_state_type acc_r;
	acc_state_type acc_nxt;
	logic [1:0]    wait_r;
	always_comb begin
		acc_nxt = acc_r;
		case (acc_r)
			acc_idle_type_s: if (access_on) acc_nxt = acc_wait_s;
			acc_wait_s:      if (!access_on) acc_nxt = acc_idle_type_s;
				else if (wait_r == `READY_DELAY_CYC) acc_nxt = acc_ready_s;
			acc_ready_s:     if (!access_on) acc_nxt = acc_idle_type_s;
			default:         acc_nxt = acc_idle_type_s;
		endcase
	end
	wire take = (acc_r == acc_idle_type_s) && access_on;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_r  <= acc_idle_type_s;
			wait_r <= '0;
		end else if (clk_en) begin
			acc_r  <= acc_nxt;
			wait_r <= (acc_r == acc_wait_s) ? wait_r + 2'h1 : 2'h0;
		end
	end

	// captured access kind on the taking edge
	logic       cyc_rd_r;
	logic       cyc_dma_r;
	logic [7:0] cyc_a_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cyc_rd_r  <= 1'b0;
			cyc_dma_r <= 1'b0;
			cyc_a_r   <= '0;
		end else if (clk_en && take) begin
			cyc_rd_r  <= rd_strobe;
			cyc_dma_r <= dma_cycle;
			cyc_a_r   <= reg_a;
		end
	end

	// register decode
	wire reg_wr = take && wr_strobe && reg_sel;
	wire reg_rd = take && rd_strobe && reg_sel;
	wire a_st0  = (reg_a == `REG_IRQ_STATUS_FIRST);
	wire a_st1  = (reg_a == `REG_IRQ_STATUS_SECOND);
	wire a_st2  = (reg_a == `REG_IRQ_STATUS_THIRD);
	wire a_mk0  = (reg_a == `REG_IRQ_MASK_FIRST);
	wire a_mk1  = (reg_a == `REG_IRQ_MASK_SECOND);
	wire a_mk2  = (reg_a == `REG_IRQ_MASK_THIRD);
	wire a_cl   = (reg_a == `REG_TX_BYTE_COUNT_LOW);
	wire a_ch   = (reg_a == `REG_TX_BYTE_COUNT_HIGH);
	wire a_fifo = (reg_a == `REG_FIFO_DATA);
	// in 16-bit mode a word write to the low count index also fills the high byte
	wire [7:0] wr_lo = din_s2_r[7:0];
	wire [7:0] wr_hi = din_s2_r[15:8];

	// interrupt status and masks; status only records unmasked sources
	logic [7:0] irq_status_first;
	logic [7:0] irq_status_second;
	logic [7:0] irq_status_third;
	logic [7:0] irq_mask_first;
	logic [7:0] irq_mask_second;
	logic [7:0] irq_mask_third;
	wire  [23:0] ev_live = irq_event & ~{irq_mask_third, irq_mask_second, irq_mask_first};
	// a read clears the register; events in the same cycle survive (set wins)
	wire  [23:0] rd_clr  = {{8{reg_rd && a_st2}}, {8{reg_rd && a_st1}}, {8{reg_rd && a_st0}}};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{irq_status_third, irq_status_second, irq_status_first} <= '0;
			irq_mask_first  <= `IRQ_MASK_RESET;
			irq_mask_second <= `IRQ_MASK_RESET;
			irq_mask_third  <= `IRQ_MASK_RESET;
		end else if (clk_en) begin
			{irq_status_third, irq_status_second, irq_status_first} <=
				({irq_status_third, irq_status_second, irq_status_first} & ~rd_clr) | ev_live;
			if (reg_wr && a_mk0 && lane_lo) irq_mask_first  <= wr_lo;
			if (reg_wr && a_mk1 && lane_lo) irq_mask_second <= wr_lo;
			if (reg_wr && a_mk2 && lane_lo) irq_mask_third  <= wr_lo;
		end
	end
	// registered level from all status bits; drops one cycle after all are cleared
	logic irq_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) irq_r <= 1'b0;
		else if (clk_en)
			irq_r <= |{irq_status_third, irq_status_second, irq_status_first};
	end

	// transmit byte count and block accounting
	logic [15:0] tx_left_r;
	logic [5:0]  tx_blk_r;
	wire  [15:0] blk_size = (tx_left_r < `DMA_BLOCK_BYTES) ? tx_left_r : `DMA_BLOCK_BYTES;
	wire         tx_in_ready;
	wire  [LW-1:0] tx_level;
	wire         dma_wr_take = take && wr_strobe && dma_cycle;
	wire         host_fifo_wr = reg_wr && a_fifo;
	wire         fifo_push = dma_wr_take || host_fifo_wr;
	wire  [15:0] push_bytes = (width16 && lane_lo && lane_hi) ? 16'h0002 : 16'h0001;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_left_r <= `TX_COUNT_RESET;
			tx_blk_r  <= '0;
		end else if (clk_en) begin
			if (reg_wr && a_cl && lane_lo) tx_left_r[7:0] <= wr_lo; // host loads count
			if (reg_wr && a_cl && lane_hi) tx_left_r[15:8] <= wr_hi;
			if (reg_wr && a_ch && lane_lo) tx_left_r[15:8] <= wr_lo;
			if (dma_wr_take && tx_in_ready) begin
				tx_left_r <= (tx_left_r > push_bytes) ? tx_left_r - push_bytes : 16'h0000;
				tx_blk_r  <= (tx_blk_r == 6'(`DMA_BLOCK_BYTES - 16'h0001)) ? 6'h00 : tx_blk_r + 6'h01;
			end
		end
	end
	// request stands while bytes remain and the fifo has room for at least one byte,
	// dropped in the very cycle the last write is taken
	wire tx_room = (FIFO_DEPTH - int'(tx_level)) > 0;
	wire last_wr = dma_wr_take && (tx_left_r <= push_bytes);
	logic tx_req_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) tx_req_r <= 1'b0;
		else if (clk_en)
			tx_req_r <= (tx_left_r != 16'h0000) && tx_room && !last_wr && (blk_size != 0);
	end
	wire tx_req_now = tx_req_r && !last_wr;

	word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.clk_en    (clk_en),
		.in_valid  (fifo_push),
		.in_ready  (tx_in_ready),
		.in_data   (lane_lo ? wr_lo : wr_hi),
		.out_valid (tx_byte_valid),
		.out_ready (tx_byte_ready),
		.out_data  (tx_byte_data),
		.level     (tx_level)
	);

	// receive path: bytes from the serial side; dma read cycles drain it
	wire         rx_out_valid;
	wire  [7:0]  rx_out_data;
	wire  [LW-1:0] rx_level;
	wire         dma_rd_take = take && rd_strobe && dma_cycle;
	wire         rx_pop = dma_rd_take || (reg_rd && a_fifo);
	word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.clk_en    (clk_en),
		.in_valid  (rx_byte_valid),
		.in_ready  (rx_byte_ready),
		.in_data   (rx_byte_data),
		.out_valid (rx_out_valid),
		.out_ready (rx_pop),
		.out_data  (rx_out_data),
		.level     (rx_level)
	);
	// request once a block is waiting (or the fifo is full, smaller fifos);
	// drops right after the falling strobe edge of the final read
	wire rx_need = (int'(rx_level) >= RX_BLOCK) || (int'(rx_level) == FIFO_DEPTH);
	logic rx_req_r;
	logic rx_burst_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_req_r   <= 1'b0;
			rx_burst_r <= 1'b0;
		end else if (clk_en) begin
			if (rx_need) rx_burst_r <= 1'b1;
			else if (dma_rd_take && (rx_level == LW'(1))) rx_burst_r <= 1'b0;
			rx_req_r <= rx_need || (rx_burst_r && !(dma_rd_take && (rx_level == LW'(1))));
		end
	end

	// read data mux, registered at the taking edge
	logic [15:0] rdata_r;
	wire  [7:0]  rd_byte = a_st0 ? irq_status_first : a_st1 ? irq_status_second :
		a_st2 ? irq_status_third : a_mk0 ? irq_mask_first : a_mk1 ? irq_mask_second :
		a_mk2 ? irq_mask_third : a_cl ? tx_left_r[7:0] : a_ch ? tx_left_r[15:8] :
		a_fifo ? rx_out_data : 8'h00;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rdata_r <= '0;
		else if (clk_en && take && rd_strobe) begin
			if (dma_cycle) rdata_r <= {8'h00, rx_out_data};
			else if (width16 && a_cl) rdata_r <= tx_left_r;
			else rdata_r <= {8'h00, rd_byte};
		end
	end

	// pins: all released in reset, ready three-stated when idle
	wire serving = (acc_r != acc_idle_type_s);
	assign data_out          = rdata_r;
	assign data_oe_n         = (serving && cyc_rd_r && (acc_r == acc_ready_s))
		? (width16 ? 16'h0000 : 16'hFF00) : 16'hFFFF;
	assign transfer_ack_out  = 1'b0;                          // ready is driven low-true
	assign transfer_ack_oe_n = !(acc_r == acc_ready_s);
	assign irq_out           = 1'b0;                          // open drain, pulls low
	assign irq_oe_n          = !irq_r;
	assign tx_dma_request_a  = tx_req_now;
	assign rx_dma_request_a  = rx_req_r;
	assign dma_req_oe_n      = !resetn;
	assign tx_bytes_left     = tx_left_r;
	// cyc_dma_r and cyc_a_r kept for debug visibility of the current cycle
	wire unused_ok = cyc_dma_r ^ (|cyc_a_r) ^ rx_out_valid ^ (|blk_size[15:6]) ^ (|tx_blk_r);
endmodule // host_bus_and_dma_request_port
`default_nettype wire

// ==== test/host_port_chk.sv ====
// host_port_chk: concurrent checks on the host port pins
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module host_port_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// bus inputs
	input wire logic        bus_width_sel,
	input wire logic        chip_select_n,
	input wire logic        read_n,
	input wire logic        write_n,
	input wire logic        read_write,
	input wire logic        data_strobe_n,
	input wire logic        low_byte_enable,
	input wire logic        high_byte_enable,
	input wire logic        dma_grant_ack_a,
	input wire logic [23:0] irq_event,
	// outputs watched
	input wire logic [15:0] data_oe_n,
	input wire logic        transfer_ack_oe_n,
	input wire logic        irq_oe_n,
	input wire logic        dma_req_oe_n,
	input wire logic        tx_dma_request_a,
	input wire logic        rx_dma_request_a,
	input wire logic [15:0] tx_bytes_left
);
	logic       strobe_idle;
	logic       sel_idle;
	logic       rd_act;
	logic [3:0] since_cause_r;
	logic [3:0] since_rd_r;
	// decoded pin states
	assign strobe_idle = read_n & write_n & data_strobe_n;
	assign sel_idle    = chip_select_n & dma_grant_ack_a;
	assign rd_act      = !chip_select_n && (!read_n || (!data_strobe_n && read_write));
	// cycles since an event or write; saturates so it never wraps
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) since_cause_r <= 4'hF;
		else if (|irq_event || !write_n) since_cause_r <= 4'h0;
		else if (since_cause_r != 4'hF) since_cause_r <= since_cause_r + 4'h1;
	end
	// cycles since a register read strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) since_rd_r <= 4'hF;
		else if (rd_act) since_rd_r <= 4'h0;
		else if (since_rd_r != 4'hF) since_rd_r <= since_rd_r + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// quiet spans long enough for the two-flop sync to settle
	sequence s_strobe_quiet;
		strobe_idle [*5];
	endsequence
	sequence s_unselected;
		sel_idle [*5];
	endsequence
	a_reset_pins_off: assert property (disable iff (1'b0) !resetn |->
		(&data_oe_n) && transfer_ack_oe_n && irq_oe_n && dma_req_oe_n)
		else $error("pin driven in reset");
	a_reset_state_clear: assert property (disable iff (1'b0) !resetn |->
		!tx_dma_request_a && !rx_dma_request_a && tx_bytes_left == 16'h0000)
		else $error("state not cleared in reset");
	a_ack_holds_on: assert property ((!transfer_ack_oe_n && !strobe_idle &&
		!sel_idle) |=> !transfer_ack_oe_n) else $error("ready dropped early");
	a_ack_needs_strobe: assert property (s_strobe_quiet |-> transfer_ack_oe_n)
		else $error("ready without strobe");
	a_ack_needs_select: assert property (s_unselected |-> transfer_ack_oe_n)
		else $error("ready without select");
	a_byte_lane_only: assert property ((!transfer_ack_oe_n && !read_n &&
		!bus_width_sel) |-> data_oe_n == 16'hFF00) else $error("8-bit read lanes wrong");
	a_word_lanes_both: assert property ((!transfer_ack_oe_n && !read_n &&
		bus_width_sel && !low_byte_enable && !high_byte_enable) |-> data_oe_n == 16'h0000)
		else $error("word read lanes wrong");
	a_irq_has_cause: assert property ($fell(irq_oe_n) |-> since_cause_r < 4'hC)
		else $error("irq without cause");
	a_irq_read_clears: assert property ($rose(irq_oe_n) |-> since_rd_r < 4'hC)
		else $error("irq cleared without read");
	a_tx_stop_at_end: assert property (tx_bytes_left == 16'h0000 |->
		!tx_dma_request_a) else $error("tx request past count");
endmodule // host_port_chk
bind host_bus_and_dma_request_port host_port_chk CHK (.*);
`default_nettype wire

// ==== test/host_master_model.sv ====
// host_master_model: processor bus master and dma controller pins
// assumes the bench calls access() and drives the style pin itself
`timescale 1ns/1ns
`default_nettype none
module host_master_model (
	// clock and observed port outputs
	input  wire logic        clk,
	input  wire logic        style,
	input  wire logic [15:0] data_out,
	input  wire logic        transfer_ack_oe_n,
	// bus pins driven by the master
	output var logic [7:0]   addr_in,
	output var logic         chip_select_n,
	output var logic         read_n,
	output var logic         write_n,
	output var logic         read_write,
	output var logic         data_strobe_n,
	output var logic         low_byte_enable,
	output var logic         high_byte_enable,
	output var logic         lower_byte_strobe,
	output var logic         upper_byte_strobe,
	output var logic [15:0]  data_in,
	output var logic         dma_grant_ack_a
);
	// idle pins; byte enables low, byte strobes high, so every access but a 16-bit strobe-style one is a full lane
	initial begin
		{addr_in, data_in} = 24'h000000;
		{chip_select_n, read_n, write_n, data_strobe_n, dma_grant_ack_a} = 5'h1F;
		{read_write, lower_byte_strobe, upper_byte_strobe} = 3'h3;
		{low_byte_enable, high_byte_enable} = 2'h0;
	end
	// one access: held until ready seen, then released; no answer in 12 cycles means refused
	task automatic access(input logic rd, input logic dack, input logic sel, input logic [7:0] a,
		input logic [15:0] wd, output logic [15:0] rdat, output logic acked);
		int n;
		@(posedge clk);
		addr_in <= a;
		data_in <= rd ? ~data_in : wd;
		chip_select_n <= ~sel;
		dma_grant_ack_a <= ~dack;
		if (style) begin
			data_strobe_n <= 1'b0;
			read_write <= rd;
		end else begin
			read_n <= ~rd;
			write_n <= rd;
		end
		acked = 1'b0;
		rdat = 16'h0000;
		for (n = 0; n < 12 && !acked; n++) begin
			@(posedge clk);
			if (transfer_ack_oe_n === 1'b0) begin
				acked = 1'b1;
				rdat = data_out;
			end
		end
		// released data line shows the inverse, never a stale copy
		{read_n, write_n, data_strobe_n, chip_select_n, dma_grant_ack_a} <= 5'h1F;
		data_in <= ~data_in;
		for (n = 0; n < 12 && transfer_ack_oe_n !== 1'b1; n++) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask
endmodule // host_master_model
`default_nettype wire

// ==== test/tb_host_bus_and_dma_request_port.sv ====
// tb_host_bus_and_dma_request_port: self-checking bench for the host port
// assumes the checker is bound in and the master model drives the bus pins
`timescale 1ns/1ns
`default_nettype none
`include "host_port_cfg.svh"
module tb_host_bus_and_dma_request_port;
	logic clk = 1'b0, resetn = 1'b1, clk_en = 1'b1, bus_width_sel = 1'b0, bus_style_select = 1'b0;
	logic [23:0] irq_event = 24'h000000;
	logic tx_byte_ready = 1'b0, rx_byte_valid = 1'b0;
	logic [7:0] rx_byte_data = 8'h00, addr_in, tx_byte_data;
	logic chip_select_n, read_n, write_n, read_write, data_strobe_n, low_byte_enable;
	logic high_byte_enable, lower_byte_strobe, upper_byte_strobe, dma_grant_ack_a;
	logic [15:0] data_in, data_out, data_oe_n, tx_bytes_left, r;
	logic transfer_ack_out, transfer_ack_oe_n, irq_out, irq_oe_n, tx_dma_request_a;
	logic rx_dma_request_a, dma_req_oe_n, tx_byte_valid, rx_byte_ready, ok;
	int miscompares = 0, n_checks = 0, tx_exp = 0;
	always #2 clk = ~clk;
	host_bus_and_dma_request_port #(.FIFO_DEPTH(8), .RX_BLOCK(4)) DUT (.clk(clk), .resetn(resetn),
		.clk_en(clk_en), .bus_width_sel(bus_width_sel), .bus_style_select(bus_style_select),
		.addr_in(addr_in), .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
		.read_write(read_write), .data_strobe_n(data_strobe_n), .low_byte_enable(low_byte_enable),
		.high_byte_enable(high_byte_enable), .lower_byte_strobe(lower_byte_strobe),
		.upper_byte_strobe(upper_byte_strobe), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .transfer_ack_out(transfer_ack_out),
		.transfer_ack_oe_n(transfer_ack_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
		.tx_dma_request_a(tx_dma_request_a), .rx_dma_request_a(rx_dma_request_a),
		.dma_req_oe_n(dma_req_oe_n), .dma_grant_ack_a(dma_grant_ack_a), .irq_event(irq_event),
		.tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_byte_data(tx_byte_data),
		.rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .rx_byte_data(rx_byte_data),
		.tx_bytes_left(tx_bytes_left));
	host_master_model PM (.clk(clk), .style(bus_style_select), .data_out(data_out),
		.transfer_ack_oe_n(transfer_ack_oe_n), .addr_in(addr_in), .chip_select_n(chip_select_n),
		.read_n(read_n), .write_n(write_n), .read_write(read_write), .data_strobe_n(data_strobe_n),
		.low_byte_enable(low_byte_enable), .high_byte_enable(high_byte_enable),
		.lower_byte_strobe(lower_byte_strobe), .upper_byte_strobe(upper_byte_strobe),
		.data_in(data_in), .dma_grant_ack_a(dma_grant_ack_a));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// one-cycle interrupt event, then time for status and request to settle
	task automatic pulse(input int idx);
		@(posedge clk) irq_event <= 24'h000001 << idx;
		@(posedge clk) irq_event <= 24'h000000;
		repeat (6) @(posedge clk);
	endtask
	// every tx byte leaving the fifo must come out in write order
	always @(posedge clk) if (tx_byte_valid === 1'b1 && tx_byte_ready === 1'b1) begin
		chk({8'h00, tx_byte_data}, {8'h00, 8'(tx_exp)});
		tx_exp++;
	end
	task automatic t_reset();
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		chk({data_oe_n[15:13], transfer_ack_oe_n, irq_oe_n, dma_req_oe_n, 10'h000}, 16'hFC00);
		chk({14'h0, transfer_ack_out, irq_out}, 16'h0000);
		chk(tx_bytes_left, 16'h0000);
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_irq();
		pulse(0);
		chk(16'(irq_oe_n), 16'h0001);
		PM.access(1'b0, 1'b0, 1'b1, `REG_IRQ_MASK_FIRST, 16'h00FE, r, ok);
		pulse(0);
		chk(16'(irq_oe_n), 16'h0000);
		PM.access(1'b1, 1'b0, 1'b1, `REG_IRQ_STATUS_FIRST, 16'h0000, r, ok);
		chk({8'h00, r[7:0]}, 16'h0001);
		repeat (4) @(posedge clk);
		chk(16'(irq_oe_n), 16'h0001);
		pulse(9);
		chk(16'(irq_oe_n), 16'h0001);
		pulse(0);
		chk(16'(irq_oe_n), 16'h0000);
		PM.access(1'b1, 1'b0, 1'b1, `REG_IRQ_STATUS_FIRST, 16'h0000, r, ok);
		PM.access(1'b1, 1'b0, 1'b1, `REG_IRQ_STATUS_FIRST, 16'h0000, r, ok);
		chk({8'h00, r[7:0]}, 16'h0000);
	endtask
	// refused strobe, unmapped read, then one read in strobe style
	task automatic t_select();
		PM.access(1'b0, 1'b0, 1'b0, `REG_IRQ_MASK_FIRST, 16'h0000, r, ok);
		chk({15'h0, ok}, 16'h0000);
		PM.access(1'b1, 1'b0, 1'b1, 8'h3F, 16'h0000, r, ok);
		chk({ok, r[14:0]}, 16'h8000);
		@(posedge clk) bus_style_select <= 1'b1;
		PM.access(1'b1, 1'b0, 1'b1, `REG_IRQ_MASK_SECOND, 16'h0000, r, ok);
		chk({ok, 7'h00, r[7:0]}, {8'h80, `IRQ_MASK_RESET});
	endtask
	// dma writes while the request stands, up to a bound
	task automatic tx_burst(inout int n, input int lim);
		while (tx_dma_request_a === 1'b1 && n < lim) begin
			PM.access(1'b0, 1'b1, 1'b0, 8'h00, {8'h00, 8'(n)}, r, ok);
			n++;
			repeat (3) @(posedge clk);
		end
	endtask
	// 34 bytes: one whole block plus a remainder, sink stalled first
	task automatic t_tx();
		int n;
		n = 0;
		@(posedge clk) bus_width_sel <= 1'b1;
		PM.access(1'b1, 1'b0, 1'b1, `REG_IRQ_MASK_FIRST, 16'h0000, r, ok);
		PM.access(1'b0, 1'b0, 1'b1, `REG_TX_BYTE_COUNT_LOW, 16'h0022, r, ok);
		chk(tx_bytes_left, 16'h0022);
		@(posedge clk) bus_width_sel <= 1'b0;
		repeat (4) @(posedge clk);
		tx_burst(n, 40);
		chk(16'(n), 16'h0008);
		@(posedge clk) tx_byte_ready <= 1'b1;
		repeat (6) @(posedge clk);
		tx_burst(n, 40);
		repeat (12) @(posedge clk);
		chk(16'(n), 16'h0022);
		chk(16'(tx_exp), 16'h0022);
		chk(tx_bytes_left, 16'h0000);
	endtask
	task automatic rx_push(input logic [7:0] v, output logic took);
		int k;
		@(posedge clk);
		rx_byte_valid <= 1'b1;
		rx_byte_data <= v;
		took = 1'b0;
		for (k = 0; k < 4 && !took; k++) begin
			@(posedge clk);
			took = (rx_byte_ready === 1'b1);
		end
		rx_byte_valid <= 1'b0;
	endtask
	// fill rx below and at the block size, until refused, then drain by dma
	task automatic t_rx();
		int i;
		int n;
		logic took;
		for (i = 0; i < 3; i++) rx_push(8'hA0 + 8'(i), took);
		repeat (8) @(posedge clk);
		chk({15'h0, rx_dma_request_a}, 16'h0000);
		rx_push(8'hA3, took);
		repeat (8) @(posedge clk);
		chk({15'h0, rx_dma_request_a}, 16'h0001);
		i = 4;
		took = 1'b1;
		while (took && i < 12) begin
			rx_push(8'hA0 + 8'(i), took);
			if (took) i++;
		end
		chk(16'(i), 16'h0008);
		n = 0;
		while (rx_dma_request_a === 1'b1 && n < 12) begin
			PM.access(1'b1, 1'b1, 1'b0, 8'h3F, 16'h0000, r, ok);
			chk({8'h00, r[7:0]}, {8'h00, 8'hA0 + 8'(n)});
			n++;
			repeat (2) @(posedge clk);
		end
		chk(16'(n), 16'h0008);
	endtask
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	initial begin
		t_reset();
		t_irq();
		t_tx();
		t_rx();
		t_select(); // last: style pin stays high
		stop_test();
	end
endmodule // tb_host_bus_and_dma_request_port
`default_nettype wire
